// [logic/ttd_top.sv]
/*
  Trigger distributor: legacy A/B channel encoder, optical trigger messages,
  software, calibration and heartbeat triggers. Assumes bunch and orbit
  ticks synchronous to MCLK and a link that drains the B channel by ready.
*/
`timescale 1ns/1ps
`include "ttd_defs.svh"

// Operation
// - every first or second level trigger is followed by its trigger message
// - A-channel code 10 means first level, 11 means second level
// - B-channel carries only the low 12 event id bits, not aligned to A
// - two A-channel triggers never start closer than 25 ns
// - legacy detectors get full trigger data through the readout path only
// - asynchronous software trigger fires as soon as it is requested
// - synchronous software trigger fires at the selected bunch crossing
// - calibration trigger emits a calibration pulse before the readout trigger
// - a heartbeat trigger marks data frame boundaries for continuous readout
// - heartbeat pulse always falls on one fixed bunch crossing
// - heartbeat carries a 2-bit normal, start or end type
// - heartbeat carries the 32-bit orbit number
// - legacy heartbeat pulse and type go as one short priority broadcast
// - legacy orbit number goes as three long 12-bit words
module ttd_top #(
  parameter int                 FIFO_DEPTH = `TTD_FIFO_DEPTH,
  parameter logic [7:0]         CAL_DELAY  = `TTD_CAL_DELAY,
  parameter logic [`TTD_BC_W-1:0] HB_BC    = `TTD_HB_BC
) (
  input  wire logic                 MCLK,
  input  wire logic                 RST_B,
  input  wire logic                 BC_TICK,
  input  wire logic                 ORBIT_TICK,
  input  wire logic                 PHYS_VALID,
  input  wire ttd_pkg::ttd_phys_req_t PHYS_REQ,
  output logic                      PHYS_READY,
  input  wire logic                 SW_VALID,
  input  wire ttd_pkg::ttd_sw_req_t SW_REQ,
  output logic                      SW_READY,
  input  wire ttd_pkg::ttd_hb_kind_t HB_KIND,
  input  wire logic                 BUSY,
  output logic                      ACH,
  output logic                      BCH_VALID,
  output ttd_pkg::ttd_bword_t       BCH_WORD,
  input  wire logic                 BCH_READY,
  output logic                      OPT_MSG_VALID,
  output logic                      RDO_VALID,
  output ttd_pkg::ttd_msg_t         TRIG_MSG,
  output logic                      OPT_HB_VALID,
  output ttd_pkg::ttd_hb_t          OPT_HB,
  output logic                      CAL_PULSE
);
  import ttd_pkg::*;

  localparam int CW = $clog2(FIFO_DEPTH+1);
  localparam logic [7:0] GAP_LOAD = 8'(`TTD_TRIG_GAP_CYC - `TTD_CODE_CYC - 1);

  typedef enum logic [2:0] {
    ST_IDLE, ST_SYNC_WAIT, ST_CAL_WAIT, ST_CODE_HI, ST_CODE_LO, ST_GAP
  } ttd_state_t;

  ttd_state_t               state_q, state_d;
  ttd_level_t               lvl_q, lvl_d;
  ttd_sel_t                 sel_q, sel_d;
  logic [`TTD_BC_W-1:0]     sw_bc_q, sw_bc_d;
  logic [7:0]               cnt_q, cnt_d;
  logic [`TTD_EVID_W-1:0]   evid_q, evid_d;
  logic                     ach_q, ach_d;
  ttd_msg_t                 msg_q, msg_d;
  logic                     msgv_q, msgv_d;
  logic                     cal_q, cal_d;
  logic                     hb_pend_q, hb_pend_d;
  ttd_hb_t                  hb_q, hb_d;
  logic                     hbv_q, hbv_d;
  logic [1:0]               orb_idx_q, orb_idx_d;
  logic [`TTD_BC_W-1:0]     bc;
  logic [`TTD_ORBIT_W-1:0]  orbit;
  logic                     hb_strobe;
  logic                     start, trig_push, orb_push, can_take;
  ttd_bword_t               fifo_in, fifo_out;
  logic                     fifo_in_valid, fifo_in_ready;
  logic                     fifo_out_valid, fifo_out_ready;
  logic [CW-1:0]            fifo_free;

  // pick one 12-bit slice of the orbit number, last word zero-padded
  function automatic logic [`TTD_BWORD_W-1:0] orbit_slice(input logic [31:0] o,
                                                         input logic [1:0] idx);
    case (idx)
      2'h3:    orbit_slice = o[11:0];
      2'h2:    orbit_slice = o[23:12];
      default: orbit_slice = {4'h0, o[31:24]};
    endcase
  endfunction : orbit_slice

  ttd_bcnt u_bcnt (
    .clk        (MCLK),
    .rst_n      (RST_B),
    .bc_tick    (BC_TICK),
    .orbit_tick (ORBIT_TICK),
    .hb_bc      (HB_BC),
    .bc_q       (bc),
    .orbit_q    (orbit),
    .hb_strobe  (hb_strobe)
  );

  // four free slots cover one event id plus a full orbit burst
  assign can_take   = (fifo_free >= CW'(4));
  assign SW_READY   = (state_q == ST_IDLE) && can_take;
  assign PHYS_READY = (state_q == ST_IDLE) && can_take && !SW_VALID && !BUSY;

  // trigger sequencer: request, optional wait, two-bit code, spacing gap
  always_comb begin
    state_d = state_q;
    lvl_d   = lvl_q;
    sel_d   = sel_q;
    sw_bc_d = sw_bc_q;
    cnt_d   = cnt_q;
    cal_d   = 1'b0;
    ach_d   = `TTD_ACH_IDLE;
    start   = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (SW_VALID && SW_READY) begin
          lvl_d   = SW_REQ.level;
          sel_d   = SW_REQ.sel;
          sw_bc_d = SW_REQ.bc;
          if (SW_REQ.kind == TTD_SW_SYNC) begin
            state_d = ST_SYNC_WAIT;
          end else if (SW_REQ.kind == TTD_SW_CAL) begin
            cal_d   = 1'b1;
            cnt_d   = CAL_DELAY;
            state_d = ST_CAL_WAIT;
          end else begin
            start = 1'b1;
          end
        end else if (PHYS_VALID && PHYS_READY) begin
          lvl_d = PHYS_REQ.level;
          sel_d = PHYS_REQ.sel;
          start = 1'b1;
        end
      end
      ST_SYNC_WAIT: begin
        // a full fifo at the chosen crossing defers to the next orbit
        start = BC_TICK && !ORBIT_TICK && (bc == sw_bc_q) && fifo_in_ready;
      end
      ST_CAL_WAIT: begin
        cnt_d = cnt_q - 1'b1;
        start = (cnt_q == 8'h01) && fifo_in_ready;
        if (cnt_q == 8'h01 && !fifo_in_ready) begin
          cnt_d = cnt_q;
        end
      end
      ST_CODE_HI: begin
        ach_d   = (lvl_q == TTD_LVL_SECOND);
        state_d = ST_CODE_LO;
      end
      ST_CODE_LO: begin
        cnt_d   = GAP_LOAD;
        state_d = ST_GAP;
      end
      default: begin
        // code takes two transmissions, so the gap pads to the spacing limit
        cnt_d = cnt_q - 1'b1;
        if (cnt_q <= 8'h01) begin
          state_d = ST_IDLE;
        end
      end
    endcase
    if (start) begin
      ach_d   = `TTD_ACH_MARK;
      state_d = ST_CODE_HI;
    end
  end

  // event numbering and the full trigger message
  always_comb begin
    evid_d = evid_q;
    msg_d  = msg_q;
    msgv_d = 1'b0;
    if (start) begin
      evid_d = evid_q + 1'b1;
      msg_d  = '{level: lvl_d, event_id: evid_q, sel: sel_d};
      msgv_d = 1'b1;
    end
  end

  // heartbeat capture: orbit and type latched at the fixed crossing
  always_comb begin
    hb_d      = hb_q;
    hbv_d     = 1'b0;
    orb_idx_d = orb_push ? orb_idx_q - 1'b1 : orb_idx_q;
    hb_pend_d = hb_pend_q;
    if (hb_pend_q && BCH_READY) begin
      hb_pend_d = 1'b0;
    end
    if (hb_strobe) begin
      hb_d      = '{kind: HB_KIND, orbit: orbit};
      hbv_d     = 1'b1;
      orb_idx_d = `TTD_ORB_WORDS;
      hb_pend_d = 1'b1; // set wins over the same-cycle send
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      state_q   <= ST_IDLE;
      lvl_q     <= TTD_LVL_FIRST;
      sel_q     <= '0;
      sw_bc_q   <= '0;
      cnt_q     <= '0;
      evid_q    <= `TTD_EVID_RST;
      ach_q     <= `TTD_ACH_IDLE;
      msg_q     <= '0;
      msgv_q    <= 1'b0;
      cal_q     <= 1'b0;
      hb_pend_q <= 1'b0;
      hb_q      <= '0;
      hbv_q     <= 1'b0;
      orb_idx_q <= '0;
    end else begin
      state_q   <= state_d;
      lvl_q     <= lvl_d;
      sel_q     <= sel_d;
      sw_bc_q   <= sw_bc_d;
      cnt_q     <= cnt_d;
      evid_q    <= evid_d;
      ach_q     <= ach_d;
      msg_q     <= msg_d;
      msgv_q    <= msgv_d;
      cal_q     <= cal_d;
      hb_pend_q <= hb_pend_d;
      hb_q      <= hb_d;
      hbv_q     <= hbv_d;
      orb_idx_q <= orb_idx_d;
    end
  end

  // event id push beats orbit words; orbit words simply wait a cycle
  assign trig_push     = start;
  assign orb_push      = (orb_idx_q != 2'h0) && !trig_push && fifo_in_ready;
  assign fifo_in_valid = trig_push || (orb_idx_q != 2'h0);
  always_comb begin
    fifo_in = '{is_short: 1'b0, data: orbit_slice(hb_q.orbit, orb_idx_q)};
    if (trig_push) begin
      fifo_in = '{is_short: 1'b0, data: evid_q[`TTD_BWORD_W-1:0]};
    end
  end

  ttd_fifo #(
    .W     ($bits(ttd_bword_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (MCLK),
    .rst_n     (RST_B),
    .in_valid  (fifo_in_valid),
    .in_data   (fifo_in),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out),
    .out_ready (fifo_out_ready),
    .free      (fifo_free)
  );

  // B channel: the short heartbeat broadcast jumps the long-word queue
  assign fifo_out_ready = BCH_READY && !hb_pend_q;
  assign BCH_VALID      = hb_pend_q || fifo_out_valid;
  always_comb begin
    BCH_WORD = fifo_out;
    if (hb_pend_q) begin
      BCH_WORD = '{is_short: 1'b1, data: {1'b1, hb_q.kind, 9'h000}};
    end
  end

  assign ACH           = ach_q;
  assign OPT_MSG_VALID = msgv_q;
  assign RDO_VALID     = msgv_q;
  assign TRIG_MSG      = msg_q;
  assign OPT_HB_VALID  = hbv_q;
  assign OPT_HB        = hb_q;
  assign CAL_PULSE     = cal_q;

  a_msg_follows_trig : assert property (@(posedge MCLK) disable iff (!RST_B)
    (state_q == ST_CODE_HI) |-> OPT_MSG_VALID && TRIG_MSG.level == lvl_q)
    else $error("trigger code without message");
  a_ach_code_bits : assert property (@(posedge MCLK) disable iff (!RST_B)
    (state_q == ST_CODE_HI) |-> ACH ##1 (ACH == (TRIG_MSG.level == TTD_LVL_SECOND)))
    else $error("wrong A channel code");
  a_bch_evid_low : assert property (@(posedge MCLK) disable iff (!RST_B)
    trig_push |=> !$past(fifo_in.is_short)
                  && TRIG_MSG.event_id[11:0] == $past(fifo_in.data))
    else $error("event id word wrong");
  a_trig_spacing : assert property (@(posedge MCLK) disable iff (!RST_B)
    (state_q == ST_CODE_HI) |=> (state_q != ST_CODE_HI)[*3])
    else $error("triggers closer than 25 ns");
  a_rdo_with_msg : assert property (@(posedge MCLK) disable iff (!RST_B)
    RDO_VALID |-> OPT_MSG_VALID && (TRIG_MSG.event_id + 32'h0000_0001) == evid_q)
    else $error("readout record missing");
  a_async_now : assert property (@(posedge MCLK) disable iff (!RST_B)
    (SW_VALID && SW_READY && SW_REQ.kind == TTD_SW_ASYNC) |=> state_q == ST_CODE_HI && ACH)
    else $error("asynchronous trigger delayed");
  a_sync_bc_hit : assert property (@(posedge MCLK) disable iff (!RST_B)
    (state_q == ST_CODE_HI && $past(state_q) == ST_SYNC_WAIT) |-> $past(bc) == sw_bc_q)
    else $error("synchronous trigger off its crossing");
  a_cal_before_trig : assert property (@(posedge MCLK) disable iff (!RST_B)
    CAL_PULSE |-> state_q == ST_CAL_WAIT && !ACH && cnt_q == CAL_DELAY)
    else $error("readout trigger before calibration pulse");
  // the wait may only end once the countdown has run out
  a_cal_wait_hold : assert property (@(posedge MCLK) disable iff (!RST_B)
    (state_q == ST_CAL_WAIT && cnt_q != 8'h01) |=> state_q == ST_CAL_WAIT)
    else $error("calibration wait cut short");
  a_hb_fixed_bc : assert property (@(posedge MCLK) disable iff (!RST_B)
    hb_strobe |=> OPT_HB_VALID && hb_pend_q && orb_idx_q == 2'h3 && $past(bc) == HB_BC)
    else $error("heartbeat off its crossing");
  a_hb_ahead : assert property (@(posedge MCLK) disable iff (!RST_B)
    hb_pend_q |-> BCH_VALID && BCH_WORD.is_short && !fifo_out_ready)
    else $error("queued word passed the heartbeat");
  a_ach_idle : assert property (@(posedge MCLK) disable iff (!RST_B)
    (state_q inside {ST_IDLE, ST_SYNC_WAIT, ST_CAL_WAIT, ST_GAP}) |-> !ACH)
    else $error("A channel not idle");

  c_sync_trig : cover property (@(posedge MCLK) disable iff (!RST_B)
    state_q == ST_SYNC_WAIT ##1 state_q == ST_CODE_HI);
  c_cal_trig : cover property (@(posedge MCLK) disable iff (!RST_B)
    state_q == ST_CAL_WAIT ##1 state_q == ST_CODE_HI);
  c_hb_queued : cover property (@(posedge MCLK) disable iff (!RST_B)
    hb_strobe && fifo_out_valid);
  c_back_to_back : cover property (@(posedge MCLK) disable iff (!RST_B)
    state_q == ST_CODE_HI ##4 state_q == ST_CODE_HI);
endmodule : ttd_top

// [logic/ttd_defs.svh]
/*
  Timing counts, field widths and reset values of the trigger
  distributor. Assumes a 125 MHz system clock; included by the package.
*/
`ifndef TTD_DEFS_SVH
`define TTD_DEFS_SVH

`define TTD_CLK_NS        8
`define TTD_TRIG_GAP_NS   25
`define TTD_TRIG_GAP_CYC  ((`TTD_TRIG_GAP_NS + `TTD_CLK_NS - 1) / `TTD_CLK_NS)
`define TTD_CODE_CYC      2
`define TTD_CAL_DELAY     8'h10
`define TTD_HB_BC         12'h010
`define TTD_BC_W          12
`define TTD_ORBIT_W       32
`define TTD_EVID_W        32
`define TTD_BWORD_W       12
`define TTD_CLASS_W       64
`define TTD_DET_W         32
`define TTD_FIFO_DEPTH    16
`define TTD_ORB_WORDS     2'h3
`define TTD_ACH_IDLE      1'b0
`define TTD_ACH_MARK      1'b1
`define TTD_EVID_RST      32'h0000_0000

`endif

// [logic/ttd_pkg.sv]
/*
  Types of the trigger distributor: request, message and link word carriers.
  Assumes ttd_defs.svh is reachable on the include path.
*/
`include "ttd_defs.svh"

package ttd_pkg;

  typedef enum logic [1:0] {TTD_HB_NORMAL, TTD_HB_START, TTD_HB_END} ttd_hb_kind_t;
  typedef enum logic [1:0] {TTD_SW_ASYNC, TTD_SW_SYNC, TTD_SW_CAL} ttd_sw_kind_t;
  typedef enum logic {TTD_LVL_FIRST, TTD_LVL_SECOND} ttd_level_t;

  typedef struct packed {
    logic [`TTD_CLASS_W-1:0] class_mask;
    logic [`TTD_DET_W-1:0]   det_mask;
  } ttd_sel_t;

  typedef struct packed {
    ttd_level_t level;
    ttd_sel_t   sel;
  } ttd_phys_req_t;

  typedef struct packed {
    ttd_sw_kind_t          kind;
    ttd_level_t            level;
    logic [`TTD_BC_W-1:0]  bc;
    ttd_sel_t              sel;
  } ttd_sw_req_t;

  typedef struct packed {
    ttd_level_t              level;
    logic [`TTD_EVID_W-1:0]  event_id;
    ttd_sel_t                sel;
  } ttd_msg_t;

  typedef struct packed {
    logic                     is_short;
    logic [`TTD_BWORD_W-1:0]  data;
  } ttd_bword_t;

  typedef struct packed {
    ttd_hb_kind_t             kind;
    logic [`TTD_ORBIT_W-1:0]  orbit;
  } ttd_hb_t;

endpackage : ttd_pkg

// [logic/ttd_fifo.sv]
/*
  Synchronous FIFO with valid/ready on both sides and a free-slot count.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`include "ttd_defs.svh"

module ttd_fifo #(
  parameter int W     = 13,
  parameter int DEPTH = `TTD_FIFO_DEPTH
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       in_valid,
  input  wire logic [W-1:0]               in_data,
  output logic                            in_ready,
  output logic                            out_valid,
  output logic [W-1:0]                    out_data,
  input  wire logic                       out_ready,
  output logic [$clog2(DEPTH+1)-1:0]      free
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic          push, pop;

  // wrap an index at the depth, which need not be a power of two
  function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
    ptr_next = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : ptr_next

  assign in_ready  = (cnt_q != CW'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign free      = CW'(DEPTH) - cnt_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer and fill level next state
  always_comb begin
    wr_d  = push ? ptr_next(wr_q) : wr_q;
    rd_d  = pop ? ptr_next(rd_q) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = CW'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = CW'(cnt_q - 1'b1);
    end
  end

  // storage has no reset: only slots below the fill level are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  a_fifo_no_overflow : assert property (@(posedge clk) disable iff (!rst_n)
    (cnt_q == CW'(DEPTH)) |-> !push) else $error("fifo pushed while full");
endmodule : ttd_fifo

// [logic/ttd_bcnt.sv]
/*
  Bunch-crossing and orbit counters with the fixed-crossing heartbeat strobe.
  Assumes bunch and orbit ticks are one-cycle pulses synchronous to the clock.
*/
`timescale 1ns/1ps
`include "ttd_defs.svh"

module ttd_bcnt (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     bc_tick,
  input  wire logic                     orbit_tick,
  input  wire logic [`TTD_BC_W-1:0]     hb_bc,
  output logic [`TTD_BC_W-1:0]          bc_q,
  output logic [`TTD_ORBIT_W-1:0]       orbit_q,
  output logic                          hb_strobe
);
  logic [`TTD_BC_W-1:0]    bc_d;
  logic [`TTD_ORBIT_W-1:0] orbit_d;

  // the orbit tick restarts the crossing count, so orbit length needs no setting
  always_comb begin
    bc_d    = bc_q;
    orbit_d = orbit_q;
    if (orbit_tick) begin
      bc_d    = '0;
      orbit_d = orbit_q + 1'b1;
    end else if (bc_tick) begin
      bc_d = bc_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bc_q    <= '0;
      orbit_q <= '0;
    end else begin
      bc_q    <= bc_d;
      orbit_q <= orbit_d;
    end
  end

  // heartbeat always on the same crossing of each orbit
  assign hb_strobe = bc_tick && !orbit_tick && (bc_q == hb_bc);
endmodule : ttd_bcnt

// [verification/ttd_link_model.sv]
/*
  Far-side model of the legacy link and readout units: drains the B channel
  with a stallable ready and returns a busy level.
  Assumes the bench drives stall and busy_req just after a falling edge.
*/
`timescale 1ns/1ps

module ttd_link_model (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                bch_valid,
  input  wire ttd_pkg::ttd_bword_t bch_word,
  input  wire logic                stall,
  input  wire logic                busy_req,
  output logic                     bch_ready,
  output logic                     busy
);
  import ttd_pkg::*;

  ttd_bword_t got[$];

  // stall holds words in the design fifo so its ordering is visible
  assign bch_ready = !stall;
  // busy is made by the readout side itself and returned on the link
  // split boards have no return path, so only this unit ever drives it
  assign busy = busy_req;

  // record every word that crosses, in arrival order
  always @(posedge clk) begin
    if (rst_n && bch_valid && bch_ready) begin
      got.push_back(bch_word);
    end
  end
endmodule : ttd_link_model

// [verification/test_trigger_timing_distributor.sv]
/*
  Self-checking bench of the trigger distributor: software, physics,
  calibration, heartbeat and buffering scenarios.
  Assumes ttd_pkg and ttd_link_model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module test_trigger_timing_distributor;
  import ttd_pkg::*;
  localparam ttd_sel_t SEL   = {64'h0123_4567_89AB_CDEF, 32'hFEDC_BA98};
  localparam int       HBB   = 3;
  localparam int       DEPTH = 16;

  logic          MCLK       = 1'b0;
  logic          RST_B      = 1'b0;
  logic          BC_TICK    = 1'b0;
  logic          ORBIT_TICK = 1'b0;
  logic          PHYS_VALID = 1'b0;
  ttd_phys_req_t PHYS_REQ   = '0;
  ttd_sw_req_t   SW_REQ     = '0;
  logic          SW_VALID   = 1'b0;
  ttd_hb_kind_t  HB_KIND    = TTD_HB_NORMAL;
  logic          stall      = 1'b0;
  logic          busy_req   = 1'b0;
  logic          PHYS_READY, SW_READY, BUSY, ACH, BCH_VALID, BCH_READY;
  logic          OPT_MSG_VALID, RDO_VALID, OPT_HB_VALID, CAL_PULSE;
  ttd_bword_t    BCH_WORD;
  ttd_msg_t      TRIG_MSG;
  ttd_hb_t       OPT_HB;
  int            mismatches = 0;
  int            compares   = 0;
  int            hb_at;
  int            ach_at;
  logic [31:0]   evid       = 32'h0000_0000;
  logic [31:0]   orbits     = 32'h0000_0000;
  ttd_bword_t    exp_q[$];

  // short calibration delay keeps the run brief; heartbeat early in the orbit
  ttd_top #(.CAL_DELAY(8'h02), .HB_BC(12'h003)) dut_u (
    .MCLK(MCLK), .RST_B(RST_B), .BC_TICK(BC_TICK), .ORBIT_TICK(ORBIT_TICK),
    .PHYS_VALID(PHYS_VALID), .PHYS_REQ(PHYS_REQ), .PHYS_READY(PHYS_READY),
    .SW_VALID(SW_VALID), .SW_REQ(SW_REQ), .SW_READY(SW_READY), .HB_KIND(HB_KIND),
    .BUSY(BUSY), .ACH(ACH), .BCH_VALID(BCH_VALID), .BCH_WORD(BCH_WORD),
    .BCH_READY(BCH_READY), .OPT_MSG_VALID(OPT_MSG_VALID), .RDO_VALID(RDO_VALID),
    .TRIG_MSG(TRIG_MSG), .OPT_HB_VALID(OPT_HB_VALID), .OPT_HB(OPT_HB),
    .CAL_PULSE(CAL_PULSE));

  ttd_link_model link_u (
    .clk(MCLK), .rst_n(RST_B), .bch_valid(BCH_VALID), .bch_word(BCH_WORD),
    .stall(stall), .busy_req(busy_req), .bch_ready(BCH_READY), .busy(BUSY));

  // 125 MHz system clock
  always #4 MCLK = ~MCLK;

  task automatic stop_test();
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  task automatic hang();
    mismatches++;
    $display("[ERR] wait exp done got timeout");
    stop_test();
  endtask : hang

  // request held from one falling edge to the next, taken at the edge between
  task automatic sw(ttd_sw_kind_t k, ttd_level_t l, logic [11:0] bc);
    int i;
    for (i = 0; i < 50 && SW_READY !== 1'b1; i++) @(negedge MCLK);
    if (i == 50) hang();
    SW_REQ   = '{kind: k, level: l, bc: bc, sel: SEL};
    SW_VALID = 1'b1;
    @(negedge MCLK);
    SW_VALID = 1'b0;
  endtask : sw

  // checks a trigger from its first code cycle through the return to idle
  task automatic trig(ttd_level_t l);
    `CHK("ach_start", 1'b1, ACH)
    `CHK("msg_valid", 1'b1, OPT_MSG_VALID)
    `CHK("rdo_valid", 1'b1, RDO_VALID)
    `CHK("event_id", evid, TRIG_MSG.event_id)
    `CHK("msg_level", l, TRIG_MSG.level)
    `CHK("msg_sel", SEL, TRIG_MSG.sel)
    exp_q.push_back('{1'b0, evid[11:0]});
    evid++;
    @(negedge MCLK);
    `CHK("ach_level", l, ACH)
    `CHK("msg_once", 1'b0, OPT_MSG_VALID)
    @(negedge MCLK);
    `CHK("ach_idle", 1'b0, ACH)
  endtask : trig

  // one orbit start then n crossings, each followed by three quiet cycles
  task automatic run_orbit(int n);
    int i;
    ORBIT_TICK = 1'b1;
    @(negedge MCLK);
    ORBIT_TICK = 1'b0;
    orbits++;
    hb_at  = -1;
    ach_at = -1;
    for (i = 0; i < n; i++) begin
      BC_TICK = 1'b1;
      @(negedge MCLK);
      BC_TICK = 1'b0;
      if (ACH === 1'b1 && ach_at < 0) ach_at = i;
      if (OPT_HB_VALID === 1'b1) begin
        hb_at = i;
        `CHK("hb_kind", HB_KIND, OPT_HB.kind)
        `CHK("hb_orbit", orbits, OPT_HB.orbit)
        if (stall) exp_q.push_front('{1'b1, {1'b1, HB_KIND, 9'h000}});
        else exp_q.push_back('{1'b1, {1'b1, HB_KIND, 9'h000}});
        exp_q.push_back('{1'b0, orbits[11:0]});
        exp_q.push_back('{1'b0, orbits[23:12]});
        exp_q.push_back('{1'b0, {4'h0, orbits[31:24]}});
      end
      repeat (3) @(negedge MCLK);
    end
  endtask : run_orbit

  // waits for the channel to empty, then compares every word in order
  task automatic drain_chk();
    int i;
    for (i = 0; i < 80 && BCH_VALID !== 1'b0; i++) @(negedge MCLK);
    if (i == 80) hang();
    `CHK("bch_count", exp_q.size(), link_u.got.size())
    for (i = 0; i < exp_q.size() && i < link_u.got.size(); i++)
      `CHK("bch_word", exp_q[i], link_u.got[i])
    exp_q.delete();
    link_u.got.delete();
  endtask : drain_chk

  task automatic t_async();
    sw(TTD_SW_ASYNC, TTD_LVL_SECOND, 12'h000);
    trig(TTD_LVL_SECOND);
    drain_chk();
  endtask : t_async

  // request held high: second start must come exactly four cycles later
  task automatic t_phys();
    int i;
    PHYS_REQ   = '{level: TTD_LVL_FIRST, sel: SEL};
    PHYS_VALID = 1'b1;
    for (i = 0; i < 20 && ACH !== 1'b1; i++) @(negedge MCLK);
    if (i == 20) hang();
    trig(TTD_LVL_FIRST);
    @(negedge MCLK);
    `CHK("ach_gap", 1'b0, ACH)
    @(negedge MCLK);
    PHYS_VALID = 1'b0;
    trig(TTD_LVL_FIRST);
    drain_chk();
  endtask : t_phys

  task automatic t_busy();
    busy_req = 1'b1;
    @(negedge MCLK);
    `CHK("phys_ready_busy", 1'b0, PHYS_READY)
    `CHK("sw_ready_busy", 1'b1, SW_READY)
    sw(TTD_SW_ASYNC, TTD_LVL_FIRST, 12'h000);
    trig(TTD_LVL_FIRST);
    busy_req = 1'b0;
    drain_chk();
  endtask : t_busy

  task automatic t_sync();
    sw(TTD_SW_SYNC, TTD_LVL_FIRST, 12'h002);
    `CHK("ach_wait", 1'b0, ACH)
    exp_q.push_back('{1'b0, evid[11:0]});
    run_orbit(5);
    `CHK("sync_bc", 2, ach_at)
    `CHK("sync_id", evid, TRIG_MSG.event_id)
    `CHK("hb_bc", HBB, hb_at)
    evid++;
    drain_chk();
  endtask : t_sync

  task automatic t_cal();
    sw(TTD_SW_CAL, TTD_LVL_SECOND, 12'h000);
    `CHK("cal_pulse", 1'b1, CAL_PULSE)
    `CHK("cal_ach", 1'b0, ACH)
    @(negedge MCLK);
    `CHK("cal_once", 1'b0, CAL_PULSE)
    `CHK("cal_ach_wait", 1'b0, ACH)
    @(negedge MCLK);
    trig(TTD_LVL_SECOND);
    drain_chk();
  endtask : t_cal

  // every marker type; the last one meets a stalled, non-empty channel
  task automatic t_hb();
    int k;
    for (k = 0; k < 3; k++) begin
      HB_KIND = ttd_hb_kind_t'(k);
      if (k == 2) begin
        stall = 1'b1;
        sw(TTD_SW_ASYNC, TTD_LVL_FIRST, 12'h000);
        trig(TTD_LVL_FIRST);
      end
      run_orbit(5);
      `CHK("hb_bc", HBB, hb_at)
      stall = 1'b0;
      drain_chk();
    end
  endtask : t_hb

  // stalled link: triggers are accepted until fewer than four slots remain
  task automatic t_fill();
    int n;
    n     = 0;
    stall = 1'b1;
    while (n < 20 && SW_READY === 1'b1) begin
      sw(TTD_SW_ASYNC, TTD_LVL_FIRST, 12'h000);
      trig(TTD_LVL_FIRST);
      @(negedge MCLK);
      n++;
    end
    `CHK("fifo_accepts", DEPTH - 3, n)
    stall = 1'b0;
    drain_chk();
  endtask : t_fill

  // reset for five cycles, then each scenario in turn
  initial begin
    repeat (5) @(negedge MCLK);
    RST_B = 1'b1;
    `CHK("ach_reset", 1'b0, ACH)
    @(negedge MCLK);
    t_async();
    t_phys();
    t_busy();
    t_sync();
    t_cal();
    t_hb();
    t_fill();
    stop_test();
  end
endmodule : test_trigger_timing_distributor
